// ===== rtl/periph_bridge_defs.svh
`ifndef PERIPH_BRIDGE_DEFS_SVH
`define PERIPH_BRIDGE_DEFS_SVH

// Peripheral address map (byte addresses on the command port).
`define ADDR_CNT_RELOAD     16'hFFB5
`define ADDR_PORT_DATA      16'hFFD6
`define ADDR_PORT_DIR       16'hFFE6
`define ADDR_CORE_MODE      16'hFF80
`define ADDR_CORE_STATUS    16'hFF81
`define ADDR_STACK_PTR_HI   16'hFF82
`define ADDR_STACK_PTR_LO   16'hFF83
`define ADDR_EXC_REQ        16'hFF84
`define ADDR_SLOW_FIRST     16'hFFE0

// Reset values.
`define RST_PORT_DATA       8'h00
`define RST_PORT_DIR        8'h00
`define RST_RELOAD          8'h00
`define RST_STACK_PTR       16'hFF00
`define RST_PC              16'h0000
`define RST_CCR             8'h80

// Read values fixed by hardware.
`define DIR_READ_VALUE      8'hFF
`define UNMAPPED_READ_VALUE 8'h00
`define WORD_LOW_FILL       8'h00

// Access timing in clock states.
`define FAST_STATES         2'd2
`define SLOW_STATES         2'd3

// Exception frame: program counter (two bytes) then condition code.
`define EXC_PUSH_BYTES      3'd3

`endif

// ===== rtl/periph_bridge_pkg.sv
package periph_bridge_pkg;

  typedef enum logic [1:0] {
    OP_READ,
    OP_WRITE,
    OP_RMW
  } bus_op_e;

  typedef enum logic [2:0] {
    BIT_SET_INSTR,
    BIT_CLEAR_INSTR,
    BIT_INVERT_INSTR,
    BIT_STORE_INSTR,
    BIT_INVERTED_STORE_INSTR
  } bit_op_e;

  typedef enum logic [2:0] {
    HALT_SLEEP_HIGH,
    HALT_SLEEP_MEDIUM,
    HALT_STANDBY,
    HALT_WATCH,
    HALT_SUBSLEEP
  } halt_mode_e;

  typedef struct packed {
    logic        valid;
    bus_op_e     op;
    logic        word;
    logic [15:0] addr;
    logic [15:0] wdata;
    bit_op_e     bop;
    logic [2:0]  bit_num;
    logic        carry;
  } core_req_s;

  typedef struct packed {
    logic        done;
    logic [15:0] rdata;
  } core_rsp_s;

  typedef struct packed {
    logic        push_valid;
    logic [15:0] push_addr;
    logic [7:0]  push_data;
  } stack_push_s;

endpackage : periph_bridge_pkg

// ===== rtl/bit_alter.sv
`timescale 1ns/1ps

// Pure bit alteration stage used between the read and write steps.
module bit_alter (
  input  wire logic [7:0]                data_i,
  input  wire periph_bridge_pkg::bit_op_e bop_i,
  input  wire logic [2:0]                bit_num_i,
  input  wire logic                      carry_i,
  output logic      [7:0]                data_o
);
  import periph_bridge_pkg::*;

  logic [7:0] mask;
  assign mask = 8'h01 << bit_num_i;

  always_comb begin
    data_o = data_i;
    unique case (bop_i)
      BIT_SET_INSTR:            data_o = data_i | mask;
      BIT_CLEAR_INSTR:          data_o = data_i & ~mask;
      BIT_INVERT_INSTR:         data_o = data_i ^ mask;
      BIT_STORE_INSTR:
        data_o = carry_i ? (data_i | mask) : (data_i & ~mask);
      BIT_INVERTED_STORE_INSTR:
        data_o = carry_i ? (data_i & ~mask) : (data_i | mask);
      default:                  data_o = data_i;
    endcase
  end
endmodule : bit_alter

// ===== rtl/port_pins.sv
`timescale 1ns/1ps
`include "periph_bridge_defs.svh"

// One port of WIDTH pins: data latch, direction control, pin read-back.
module port_pins #(
  parameter int WIDTH = 8
) (
  input  wire logic             clk_i,
  input  wire logic             resetn_i,
  input  wire logic             data_we_i,
  input  wire logic             dir_we_i,
  input  wire logic [WIDTH-1:0] wdata_i,
  input  wire logic [WIDTH-1:0] pin_i,
  output logic      [WIDTH-1:0] read_o,
  output logic      [WIDTH-1:0] pin_o,
  output logic      [WIDTH-1:0] pin_oe_o
);
  logic [WIDTH-1:0] latch_q;
  logic [WIDTH-1:0] dir_q;

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      latch_q <= WIDTH'(`RST_PORT_DATA);
      dir_q   <= WIDTH'(`RST_PORT_DIR);
    end else begin
      if (data_we_i) latch_q <= wdata_i;
      if (dir_we_i)  dir_q   <= wdata_i;
    end
  end

  for (genvar g = 0; g < WIDTH; g++) begin : g_pin
    assign pin_oe_o[g] = dir_q[g];
    assign pin_o[g]    = latch_q[g];
    assign read_o[g]   = dir_q[g] ? latch_q[g] : pin_i[g];
  end
endmodule : port_pins

// ===== rtl/periph_bridge.sv
// Behaviour
// - Halt state offers five low-power modes.
// - Reset or interrupt enters transient exception state.
// - Interrupt exception pushes program counter and flags.
// - Writes to unmapped addresses are discarded.
// - Reads from unmapped addresses are undefined.
// - Peripheral data path is one byte wide.
// - Word write stores only the upper byte.
// - Word read puts byte in upper half.
// - Bit instructions read, alter, then write back.
// - Shared address: read counter, write reload.
// - Port data read returns pins for inputs.
// - Direction bit zero input, one output.
// - Output pin drives its data latch bit.
// - Direction register always reads all ones.
// - Accesses take two or three clock states.
//
// Chosen here: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`include "periph_bridge_defs.svh"

module periph_bridge #(
  parameter int PORT_WIDTH = 8
) (
  input  wire logic                          clk_i,
  input  wire logic                          resetn_i,
  input  wire periph_bridge_pkg::core_req_s  req_i,
  input  wire logic                          irq_i,
  input  wire logic [15:0]                   irq_pc_i,
  input  wire logic [7:0]                    irq_ccr_i,
  input  wire logic                          sleep_i,
  input  wire logic                          wake_i,
  input  wire logic [15:0]                   addr_i,
  input  wire logic [7:0]                    wdata_i,
  input  wire logic                          wr_i,
  input  wire logic                          rd_i,
  input  wire logic [PORT_WIDTH-1:0]         pin_i,
  output periph_bridge_pkg::core_rsp_s       rsp_o,
  output periph_bridge_pkg::stack_push_s     push_o,
  output logic                               busy_o,
  output logic                               exc_active_o,
  output logic                               halted_o,
  output logic [7:0]                         rdata_o,
  output logic [7:0]                         counter_o,
  output logic [PORT_WIDTH-1:0]              pin_o,
  output logic [PORT_WIDTH-1:0]              pin_oe_o
);
  import periph_bridge_pkg::*;

  typedef enum logic [2:0] {
    S_RESET,
    S_EXEC,
    S_ACCESS,
    S_ALTER,
    S_EXCEPT,
    S_HALT
  } core_state_e;

  core_state_e core_state_q, core_state_d;
  core_req_s   req_q;
  core_rsp_s   rsp_q;
  stack_push_s push_q;
  logic [1:0]  wait_q;
  logic [2:0]  push_cnt_q;
  logic [7:0]  byte_q;
  logic [15:0] sp_q;
  logic [15:0] pc_save_q;
  logic [7:0]  ccr_save_q;
  logic        irq_exc_q;
  logic [2:0]  halt_mode_q;
  logic [7:0]  counter_q;
  logic [7:0]  reload_q;
  logic [7:0]  rdata_q;
  logic        pending_irq_q;

  // Decoding of the peripheral byte address carried by a core request.
  wire logic        hit_cnt   = req_q.addr == `ADDR_CNT_RELOAD;
  wire logic        hit_data  = req_q.addr == `ADDR_PORT_DATA;
  wire logic        hit_dir   = req_q.addr == `ADDR_PORT_DIR;
  wire logic        hit_any   = hit_cnt | hit_data | hit_dir;
  wire logic        slow      = req_q.addr >= `ADDR_SLOW_FIRST;
  wire logic [1:0]  n_states  = slow ? `SLOW_STATES : `FAST_STATES;
  wire logic [PORT_WIDTH-1:0] port_rd;
  wire logic [7:0]  port_rd8  = 8'(port_rd);

  wire logic [7:0]  periph_rd =
      hit_cnt  ? counter_q :
      hit_data ? port_rd8 :
      hit_dir  ? `DIR_READ_VALUE : `UNMAPPED_READ_VALUE;

  // Word writes carry only the upper byte.
  wire logic [7:0]  wr_byte   = req_q.word ? req_q.wdata[15:8]
                                           : req_q.wdata[7:0];
  wire logic [7:0]  altered;
  wire logic        access_end = core_state_q == S_ACCESS &&
                                 wait_q == n_states - 2'd1;
  wire logic        do_write  = (core_state_q == S_ALTER) ||
                                (access_end && req_q.op == OP_WRITE);
  wire logic [7:0]  store_byte = core_state_q == S_ALTER ? altered
                                                          : wr_byte;
  wire logic        we_cnt    = do_write & hit_cnt;
  wire logic        we_data   = do_write & hit_data;
  wire logic        we_dir    = do_write & hit_dir;

  // Software register port for mode, stack and exception control.
  wire logic        sw_mode   = addr_i == `ADDR_CORE_MODE;
  wire logic        sw_sph    = addr_i == `ADDR_STACK_PTR_HI;
  wire logic        sw_spl    = addr_i == `ADDR_STACK_PTR_LO;
  wire logic        sw_exc    = addr_i == `ADDR_EXC_REQ;
  wire logic        sw_stat   = addr_i == `ADDR_CORE_STATUS;
  wire logic        irq_take  = irq_i | (wr_i & sw_exc & wdata_i[0]);
  wire logic [7:0]  status_rd = {2'b00, halt_mode_q,
                                 core_state_q == S_HALT,
                                 core_state_q == S_EXCEPT, busy_o};
  wire logic [7:0]  sw_rd =
      sw_mode ? {5'b00000, halt_mode_q} :
      sw_stat ? status_rd :
      sw_sph  ? sp_q[15:8] :
      sw_spl  ? sp_q[7:0] : `UNMAPPED_READ_VALUE;

  // Frame order: pc low, pc high, flags.
  wire logic [7:0]  push_byte =
      push_cnt_q == 3'd0 ? pc_save_q[7:0] :
      push_cnt_q == 3'd1 ? pc_save_q[15:8] : ccr_save_q;

  bit_alter u_alter (
    .data_i    (byte_q),
    .bop_i     (req_q.bop),
    .bit_num_i (req_q.bit_num),
    .carry_i   (req_q.carry),
    .data_o    (altered)
  );

  port_pins #(.WIDTH(PORT_WIDTH)) u_port (
    .clk_i     (clk_i),
    .resetn_i  (resetn_i),
    .data_we_i (we_data),
    .dir_we_i  (we_dir),
    .wdata_i   (store_byte[PORT_WIDTH-1:0]),
    .pin_i     (pin_i),
    .read_o    (port_rd),
    .pin_o     (pin_o),
    .pin_oe_o  (pin_oe_o)
  );

  always_comb begin
    core_state_d = core_state_q;
    unique case (core_state_q)
      S_RESET:  core_state_d = S_EXCEPT;
      S_EXEC: begin
        if (pending_irq_q)    core_state_d = S_EXCEPT;
        else if (sleep_i)     core_state_d = S_HALT;
        else if (req_i.valid) core_state_d = S_ACCESS;
      end
      S_ACCESS: if (access_end) begin
        core_state_d = req_q.op == OP_RMW ? S_ALTER : S_EXEC;
      end
      S_ALTER:  core_state_d = S_EXEC;
      S_EXCEPT: if (!irq_exc_q || push_cnt_q == `EXC_PUSH_BYTES - 3'd1)
        core_state_d = S_EXEC;
      // Any halt mode leaves on wake.
      S_HALT:   if (wake_i || pending_irq_q) core_state_d = S_EXEC;
      default:  core_state_d = S_RESET;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      core_state_q <= S_RESET;
      pending_irq_q <= 1'b0;
    end else begin
      core_state_q <= core_state_d;
      // An arriving request wins over the clear at exception entry.
      if (irq_take)
        pending_irq_q <= 1'b1;
      else if (core_state_q == S_EXCEPT)
        pending_irq_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      req_q <= '0;
      wait_q <= 2'd0;
      byte_q <= 8'h00;
      rsp_q <= '0;
    end else begin
      rsp_q.done <= 1'b0;
      if (core_state_q == S_EXEC && core_state_d == S_ACCESS)
        req_q <= req_i;
      wait_q <= core_state_q == S_ACCESS && !access_end
              ? wait_q + 2'd1 : 2'd0;
      // Only one byte crosses the bus.
      if (access_end) byte_q <= periph_rd;
      if (access_end && req_q.op != OP_RMW) begin
        rsp_q.done  <= 1'b1;
        rsp_q.rdata <= req_q.word ? {periph_rd, `WORD_LOW_FILL}
                                  : {8'h00, periph_rd};
      end
      if (core_state_q == S_ALTER) begin
        rsp_q.done  <= 1'b1;
        rsp_q.rdata <= {8'h00, altered};
      end
    end
  end

  // Counter reloads from its reload register.
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      counter_q <= `RST_RELOAD;
      reload_q  <= `RST_RELOAD;
    end else begin
      if (we_cnt) reload_q <= store_byte;
      counter_q <= counter_q == 8'hFF ? reload_q : counter_q + 8'h01;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      sp_q <= `RST_STACK_PTR;
      push_cnt_q <= 3'd0;
      push_q <= '0;
      irq_exc_q <= 1'b0;
      pc_save_q <= `RST_PC;
      ccr_save_q <= `RST_CCR;
      halt_mode_q <= 3'd0;
      rdata_q <= 8'h00;
    end else begin
      push_q.push_valid <= 1'b0;
      rdata_q <= rd_i ? sw_rd : 8'h00;
      if (wr_i && sw_mode && wdata_i[2:0] <= 3'(HALT_SUBSLEEP))
        halt_mode_q <= wdata_i[2:0];
      if (core_state_q == S_EXEC && core_state_d == S_EXCEPT) begin
        irq_exc_q  <= 1'b1;
        pc_save_q  <= irq_pc_i;
        ccr_save_q <= irq_ccr_i;
        push_cnt_q <= 3'd0;
      end else if (core_state_q == S_EXCEPT && irq_exc_q) begin
        push_q.push_valid <= 1'b1;
        push_q.push_addr  <= sp_q - 16'd1;
        push_q.push_data  <= push_byte;
        sp_q <= sp_q - 16'd1;
        push_cnt_q <= push_cnt_q + 3'd1;
        if (core_state_d == S_EXEC) irq_exc_q <= 1'b0;
      end else if (wr_i && sw_sph) begin
        sp_q[15:8] <= wdata_i;
      end else if (wr_i && sw_spl) begin
        sp_q[7:0] <= wdata_i;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      busy_o <= 1'b0;
      exc_active_o <= 1'b0;
      halted_o <= 1'b0;
    end else begin
      busy_o       <= core_state_d == S_ACCESS || core_state_d == S_ALTER;
      exc_active_o <= core_state_d == S_EXCEPT;
      halted_o     <= core_state_d == S_HALT;
    end
  end

  assign rsp_o     = rsp_q;
  assign push_o    = push_q;
  assign rdata_o   = rdata_q;
  assign counter_o = counter_q;

  property p_dir_reads_ones;
    @(posedge clk_i) disable iff (!resetn_i)
    access_end && hit_dir && req_q.op == OP_READ |=>
      rsp_q.rdata[7:0] == 8'hFF || rsp_q.rdata[15:8] == 8'hFF;
  endproperty
  a_dir_reads_ones: assert property (p_dir_reads_ones)
    else $error("direction register did not read all ones");

  property p_unmapped_no_store;
    @(posedge clk_i) disable iff (!resetn_i)
    do_write && !hit_any |-> !we_cnt && !we_data && !we_dir;
  endproperty
  a_unmapped_no_store: assert property (p_unmapped_no_store)
    else $error("unmapped write reached a register");

  property p_word_low_zero;
    @(posedge clk_i) disable iff (!resetn_i)
    access_end && req_q.word && req_q.op == OP_READ |=>
      rsp_q.done && rsp_q.rdata[7:0] == 8'h00;
  endproperty
  a_word_low_zero: assert property (p_word_low_zero)
    else $error("word read lower byte not zero");

  sequence s_rmw_read;
    core_state_q == S_ACCESS && req_q.op == OP_RMW && access_end;
  endsequence
  property p_rmw_order;
    @(posedge clk_i) disable iff (!resetn_i)
    s_rmw_read |=> core_state_q == S_ALTER && do_write ##1
      core_state_q == S_EXEC;
  endproperty
  a_rmw_order: assert property (p_rmw_order)
    else $error("bit operation did not write back after read");

  property p_access_states;
    @(posedge clk_i) disable iff (!resetn_i)
    core_state_q == S_EXEC && core_state_d == S_ACCESS |=>
      ##[1:2] access_end;
  endproperty
  a_access_states: assert property (p_access_states)
    else $error("access took wrong number of states");

  property p_exc_push;
    @(posedge clk_i) disable iff (!resetn_i)
    $rose(exc_active_o) && irq_exc_q |-> ##[0:1] push_o.push_valid[*3];
  endproperty
  a_exc_push: assert property (p_exc_push)
    else $error("exception frame not pushed");

  property p_reset_exc;
    @(posedge clk_i) core_state_q == S_RESET && resetn_i |=>
      core_state_q == S_EXCEPT;
  endproperty
  a_reset_exc: assert property (p_reset_exc)
    else $error("reset did not enter exception handling");

  property p_cnt_write_reload;
    @(posedge clk_i) disable iff (!resetn_i)
    we_cnt |=> reload_q == $past(store_byte);
  endproperty
  a_cnt_write_reload: assert property (p_cnt_write_reload)
    else $error("shared address write missed reload register");
endmodule : periph_bridge

// ===== tb/core_model.sv
`timescale 1ns/1ps

// Processor core side: issues one byte or word access and waits for done.
module core_model (
  input  wire periph_bridge_pkg::core_rsp_s clk_unused_i,
  input  wire logic                         clk_i,
  input  wire periph_bridge_pkg::core_rsp_s rsp_i,
  output periph_bridge_pkg::core_req_s      req_o
);
  import periph_bridge_pkg::*;

  initial req_o = '0;

  // byte or word transfers, one at a time
  task automatic access(
    input  bus_op_e     op,
    input  logic        word,
    input  logic [15:0] addr,
    input  logic [15:0] wdata,
    input  bit_op_e     bop,
    input  logic [2:0]  bn,
    input  logic        carry,
    output logic [15:0] rdata,
    output int          states
  );
    states = 0;
    @(posedge clk_i);
    req_o <= '{1'b1, op, word, addr, wdata, bop, bn, carry};
    // Valid is held until done is seen, then dropped before the next edge so the request is not taken twice.
    do begin
      @(posedge clk_i);
      #1;
      states++;
    end while (rsp_i.done !== 1'b1 && states < 20);
    rdata = rsp_i.rdata;
    req_o.valid <= 1'b0;
  endtask : access
endmodule : core_model

// ===== tb/cpu_peripheral_access_rmw_test.sv
`timescale 1ns/1ps
`include "periph_bridge_defs.svh"

module cpu_peripheral_access_rmw_test;
  import periph_bridge_pkg::*;

  logic        clk_i;
  logic        resetn_i;
  core_req_s   req;
  core_rsp_s   rsp;
  stack_push_s push;
  logic        irq_i;
  logic [15:0] irq_pc_i;
  logic [7:0]  irq_ccr_i;
  logic        sleep_i;
  logic        wake_i;
  logic [15:0] addr_i;
  logic [7:0]  wdata_i;
  logic        wr_i;
  logic        rd_i;
  logic [7:0]  pin_i;
  logic        busy_o;
  logic        exc_o;
  logic        halted_o;
  logic [7:0]  rdata_o;
  logic [7:0]  counter_o;
  logic [7:0]  pin_o;
  logic [7:0]  pin_oe_o;
  logic [15:0] rd;
  int          st;
  int          num_errors;
  int          n_checks;

  periph_bridge #(.PORT_WIDTH(8)) DUT (
    .clk_i(clk_i), .resetn_i(resetn_i), .req_i(req), .irq_i(irq_i),
    .irq_pc_i(irq_pc_i), .irq_ccr_i(irq_ccr_i), .sleep_i(sleep_i),
    .wake_i(wake_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .pin_i(pin_i), .rsp_o(rsp), .push_o(push),
    .busy_o(busy_o), .exc_active_o(exc_o), .halted_o(halted_o),
    .rdata_o(rdata_o), .counter_o(counter_o), .pin_o(pin_o),
    .pin_oe_o(pin_oe_o)
  );

  core_model CORE (
    .clk_unused_i('0), .clk_i(clk_i), .rsp_i(rsp), .req_o(req)
  );

  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic end_of_test;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_of_test

  task automatic go(bus_op_e op, logic w, logic [15:0] a, logic [15:0] d,
                    bit_op_e b, logic [2:0] n, logic c);
    CORE.access(op, w, a, d, b, n, c, rd, st);
    if (st >= 20) begin
      num_errors++;
      end_of_test();
    end
  endtask : go

  task automatic reg_wr(logic [15:0] a, logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    d = rdata_o;
  endtask : reg_rd

  task automatic t_port;
    @(posedge clk_i);
    pin_i <= 8'h40;
    go(OP_WRITE, 1'b0, `ADDR_PORT_DIR, 16'h003F, BIT_SET_INSTR, 3'h0, 1'b0);
    check("slow_states", 16'(st), 16'h0004);
    go(OP_WRITE, 1'b0, `ADDR_PORT_DATA, 16'h0080, BIT_SET_INSTR, 3'h0, 1'b0);
    check("dir", pin_oe_o, 16'h003F);
    check("latch", pin_o, 16'h0080);
    go(OP_READ, 1'b0, `ADDR_PORT_DATA, 16'h0000, BIT_SET_INSTR, 3'h0, 1'b0);
    check("port_rd", rd, 16'h0040);
    check("fast_states", 16'(st), 16'h0003);
    go(OP_READ, 1'b0, `ADDR_PORT_DIR, 16'h0000, BIT_SET_INSTR, 3'h0, 1'b0);
    check("dir_rd", rd, 16'h00FF);
    go(OP_RMW, 1'b0, `ADDR_PORT_DATA, 16'h0000, BIT_SET_INSTR, 3'h0, 1'b0);
    check("bit_set_instr_port", pin_o, 16'h0041);
    check("rmw_states", 16'(st), 16'h0004);
    go(OP_RMW, 1'b0, `ADDR_PORT_DIR, 16'h0000, BIT_CLEAR_INSTR, 3'h0, 1'b0);
    check("bit_clear_instr_dir", pin_oe_o, 16'h00FE);
  endtask : t_port

  task automatic t_bitops;
    logic [7:0] e;
    bit_op_e    op;
    go(OP_WRITE, 1'b0, `ADDR_PORT_DIR, 16'h00FF, BIT_SET_INSTR, 3'h0, 1'b0);
    go(OP_WRITE, 1'b0, `ADDR_PORT_DATA, 16'h00A5, BIT_SET_INSTR, 3'h0, 1'b0);
    e = 8'hA5;
    for (int i = 0; i < 5; i++) begin
      op = bit_op_e'(i);
      case (op)
        BIT_SET_INSTR:    e[i+1] = 1'b1;
        BIT_CLEAR_INSTR:  e[i+1] = 1'b0;
        BIT_INVERT_INSTR: e[i+1] = ~e[i+1];
        BIT_STORE_INSTR:  e[i+1] = i[0];
        default:          e[i+1] = ~i[0];
      endcase
      go(OP_RMW, 1'b0, `ADDR_PORT_DATA, 16'h0000, op, 3'(i + 1), i[0]);
      check("bitop_pin", pin_o, e);
      check("bitop_rd", rd[7:0], e);
    end
    go(OP_WRITE, 1'b1, `ADDR_PORT_DATA, 16'h5AC3, BIT_SET_INSTR, 3'h0, 1'b0);
    check("word_wr", pin_o, 16'h005A);
    go(OP_READ, 1'b1, `ADDR_PORT_DATA, 16'h0000, BIT_SET_INSTR, 3'h0, 1'b0);
    check("word_rd", rd, 16'h5A00);
    go(OP_WRITE, 1'b0, 16'hFFB0, 16'h0011, BIT_SET_INSTR, 3'h0, 1'b0);
    check("unmapped_wr", pin_o, 16'h005A);
    go(OP_READ, 1'b0, 16'hFFB0, 16'h0000, BIT_SET_INSTR, 3'h0, 1'b0);
    check("unmapped_rd", rd, 16'h0000);
    reg_rd(16'hFF90, e);
    check("sw_unmapped", e, 16'h0000);
  endtask : t_bitops

  task automatic t_counter;
    int n;
    go(OP_RMW, 1'b0, `ADDR_CNT_RELOAD, 16'h0000, BIT_SET_INSTR, 3'h0, 1'b0);
    check("reload_bit", rd[0], 16'h0001);
    n = 0;
    while (counter_o !== 8'hFF && n < 300) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    if (n >= 300) begin
      num_errors++;
      end_of_test();
    end
    @(posedge clk_i);
    #1;
    check("reload", counter_o, rd[7:0]);
  endtask : t_counter

  task automatic t_exc;
    logic [7:0] v;
    logic       seen;
    int         k;
    reg_wr(`ADDR_STACK_PTR_HI, 8'h12);
    reg_wr(`ADDR_STACK_PTR_LO, 8'h40);
    @(posedge clk_i);
    irq_pc_i <= 16'hABCD;
    irq_ccr_i <= 8'h5C;
    irq_i <= 1'b1;
    @(posedge clk_i);
    irq_i <= 1'b0;
    k = 0;
    seen = 1'b0;
    repeat (30) begin
      @(posedge clk_i);
      #1;
      seen |= (exc_o === 1'b1);
      if (push.push_valid === 1'b1 && k < 3) begin
        check("push_addr", push.push_addr, 16'h1240 - 16'(k + 1));
        check("push_data", push.push_data,
              k == 0 ? 16'h00CD : k == 1 ? 16'h00AB : 16'h005C);
        k++;
      end
    end
    check("pushes", 16'(k), 16'h0003);
    check("exc_seen", seen, 16'h0001);
    reg_rd(`ADDR_STACK_PTR_LO, v);
    check("sp_after", v, 16'h003D);
  endtask : t_exc

  task automatic t_halt;
    logic [7:0] v;
    for (int m = 0; m < 5; m++) begin
      reg_wr(`ADDR_CORE_MODE, 8'(m));
      @(posedge clk_i);
      sleep_i <= 1'b1;
      @(posedge clk_i);
      sleep_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      #1;
      check("halted", halted_o, 16'h0001);
      reg_rd(`ADDR_CORE_STATUS, v);
      check("status", v, {2'h0, 3'(m), 3'h4});
      @(posedge clk_i);
      wake_i <= 1'b1;
      @(posedge clk_i);
      wake_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      #1;
      check("woken", halted_o, 16'h0000);
    end
  endtask : t_halt

  initial begin
    logic [7:0] v;
    logic       seen;
    {resetn_i, irq_i, sleep_i, wake_i, wr_i, rd_i} = '0;
    {irq_pc_i, irq_ccr_i, addr_i, wdata_i, pin_i} = '0;
    num_errors = 0;
    n_checks = 0;
    seen = 1'b0;
    repeat (12) @(posedge clk_i);
    resetn_i <= 1'b1;
    repeat (3) begin
      @(posedge clk_i);
      #1;
      seen |= (exc_o === 1'b1);
    end
    check("reset_exc", seen, 16'h0001);
    check("reset_dir", pin_oe_o, 16'h0000);
    reg_rd(`ADDR_STACK_PTR_HI, v);
    check("reset_sp", v, 16'(`RST_STACK_PTR >> 8));
    t_port();
    t_bitops();
    t_counter();
    t_exc();
    t_halt();
    end_of_test();
  end
endmodule : cpu_peripheral_access_rmw_test
